// ==== core/dba_pkg.sv ====
// package for the drive bus adapter register block
// assumes a single 40 MHz system-bus clock domain
package dba_pkg;
  // register offsets
  localparam logic [11:0] OFS_CONFIG_STATUS = 12'h000;
  localparam logic [11:0] OFS_CONTROL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  // config/status bit positions
  localparam int CS_PARITY = 31;
  localparam int CS_WR_MISSING = 30;
  localparam int CS_UNEXP_READ = 29;
  localparam int CS_MULTI_DRV = 27;
  localparam int CS_SEND_ERR = 26;
  localparam int CS_PWR_LOST = 23;
  localparam int CS_PWR_GOOD = 22;
  localparam int CS_OVERHEAT = 21;
  localparam int CS_CODE_MSB = 7;
  // control bit positions
  localparam int CR_DIAG = 3;
  localparam int CR_IRQ_PERMIT = 2;
  localparam int CR_ABORT = 1;
  localparam int CR_INIT = 0;
  // status bit positions
  localparam int SR_ACTIVE = 31;
  localparam int SR_NO_REPLY = 30;
  localparam int SR_CORRECTED = 29;
  localparam int SR_MISUSE = 19;
  localparam int SR_ABORTED = 12;
  // reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // arbitrary adapter type code, not tied to any real part
  localparam logic [7:0] ADAPTER_CODE_DEFAULT = 8'h5A;
  // confirmation slot spacing after a transmit
  localparam int CONFIRM_DELAY = 2;

  // abort sequence states
  typedef enum logic [1:0] {
    AB_IDLE = 2'b00,
    AB_WAIT_EBL = 2'b01,
    AB_WAIT_TRAIL = 2'b10
  } dba_abort_e;

  // system bus event inputs
  typedef struct packed {
    logic parity_err;
    logic write_cmd_sent;
    logic write_tag_ok;
    logic read_data_seen;
    logic read_outstanding;
    logic transmitting;
    logic id_mismatch;
    logic no_reply;
    logic corrected;
    logic xfer_start;
    logic xfer_done;
  } dba_sysev_s;

  // drive-side outputs
  typedef struct packed {
    logic run;
    logic drive_request_strobe;
    logic detach;
    logic transfer_exception_line;
    logic drive_init;
  } dba_drive_s;
endpackage : dba_pkg

// ==== core/dba_regs.sv ====
// register block of the drive bus adapter: config/status, control, status
// assumes synchronous inputs, one clock, register port with write/read strobes
// read data is registered and stands the cycle after the read strobe
// fault flags clear when the system-bus error line is released or on an init write
`timescale 1ns/1ps
`default_nettype none
module dba_regs #(
  parameter logic [7:0] ADAPTER_CODE = dba_pkg::ADAPTER_CODE_DEFAULT
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // register port
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [11:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  output logic [31:0] RDATA_OUT,
  // system bus side
  input wire dba_pkg::dba_sysev_s SYSEV_IN,
  input wire logic SYS_FAULT_IN,
  input wire logic BUS_CLEAR_LINE_IN,
  input wire logic SUPPLY_LOW_LINE_IN,
  input wire logic POWER_OK_IN,
  input wire logic END_OF_BLOCK_LINE_IN,
  output logic SYS_FAULT_OUT,
  output logic RETRY_OUT,
  output logic STOP_COMMANDS_OUT,
  output logic IRQ_OUT,
  // drive side
  output dba_pkg::dba_drive_s DRIVE_OUT
);
  import dba_pkg::*;

  // pipe slicing and code field need these package sizes
  if (CONFIRM_DELAY < 2) begin : g_delay_check
    $error("confirm delay below two stages");
  end
  if (CS_CODE_MSB != 7) begin : g_code_check
    $error("type code field must be eight bits");
  end

  logic [31:0] cs_reg, cs_next;
  logic [31:0] cr_reg, cr_next;
  logic [31:0] sr_reg, sr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic fault_reg, fault_next;
  logic fault_seen_reg, fault_seen_next;
  logic wr_pend_reg, wr_pend_next;
  logic [CONFIRM_DELAY-1:0] tx_pipe_reg, tx_pipe_next;
  logic mt_pend_reg, mt_pend_next;
  logic pwr_reg, pwr_next;
  logic retry_reg, retry_next;
  logic irq_reg, irq_next;
  logic init_reg, init_next;
  logic ebl_reg, ebl_next;
  dba_abort_e ab_reg, ab_next;
  dba_drive_s drv_reg, drv_next;

  function automatic logic hit(input logic [11:0] ofs);
    hit = WR_EN_IN && (ADDR_IN == ofs);
  endfunction : hit

  logic wr_cs, wr_cr, wr_sr, do_init, busy, fault_release, irq_src, pwr_rise;

  always_comb begin
    wr_cs = hit(OFS_CONFIG_STATUS);
    wr_cr = hit(OFS_CONTROL);
    wr_sr = hit(OFS_STATUS);
    do_init = wr_cr && WDATA_IN[CR_INIT];
    busy = sr_reg[SR_ACTIVE];
    fault_release = fault_seen_reg && !SYS_FAULT_IN;
    pwr_rise = POWER_OK_IN && !pwr_reg;
    cs_next = cs_reg;
    cr_next = cr_reg;
    sr_next = sr_reg;
    fault_next = 1'b0;
    fault_seen_next = SYS_FAULT_IN;
    // tag check falls in the cycle after the write command
    wr_pend_next = SYSEV_IN.write_cmd_sent;
    tx_pipe_next = {tx_pipe_reg[CONFIRM_DELAY-2:0], SYSEV_IN.transmitting};
    // mismatch held a cycle so the fault lands on the confirm slot
    mt_pend_next = SYSEV_IN.transmitting && SYSEV_IN.id_mismatch;
    // last level kept so power-good reacts to the rising edge only
    pwr_next = POWER_OK_IN;
    retry_next = 1'b0;
    init_next = do_init;
    ebl_next = END_OF_BLOCK_LINE_IN;
    ab_next = ab_reg;
    // fault flags drop when the fault line is released
    // init clears them as well
    if (fault_release || do_init) begin
      cs_next[CS_PARITY] = 1'b0;
      cs_next[CS_WR_MISSING] = 1'b0;
      cs_next[CS_UNEXP_READ] = 1'b0;
      cs_next[CS_MULTI_DRV] = 1'b0;
      cs_next[CS_SEND_ERR] = 1'b0;
    end
    if (do_init) begin
      cs_next[CS_PWR_GOOD] = 1'b0;
      sr_next = ZERO_WORD;
      cr_next = ZERO_WORD;
      ab_next = AB_IDLE;
    end else if (wr_cr) begin
      cr_next[CR_IRQ_PERMIT] = WDATA_IN[CR_IRQ_PERMIT];
      cr_next[CR_ABORT] = WDATA_IN[CR_ABORT];
      if (!busy) cr_next[CR_DIAG] = WDATA_IN[CR_DIAG];
      if (busy && WDATA_IN[CR_DIAG]) sr_next[SR_MISUSE] = 1'b1;
      if (WDATA_IN[CR_ABORT] && ab_reg == AB_IDLE) ab_next = AB_WAIT_EBL;
    end
    // write-one clears; sets below win over them
    if (wr_cs && WDATA_IN[CS_PWR_GOOD]) cs_next[CS_PWR_GOOD] = 1'b0;
    if (wr_sr && !do_init) begin
      sr_next[SR_NO_REPLY] = sr_reg[SR_NO_REPLY] & ~WDATA_IN[SR_NO_REPLY];
      sr_next[SR_CORRECTED] = sr_reg[SR_CORRECTED]
        & ~WDATA_IN[SR_CORRECTED];
      sr_next[SR_MISUSE] = sr_next[SR_MISUSE] & ~WDATA_IN[SR_MISUSE];
      sr_next[SR_ABORTED] = sr_reg[SR_ABORTED] & ~WDATA_IN[SR_ABORTED];
    end
    if (BUS_CLEAR_LINE_IN) begin
      cr_next[CR_ABORT] = 1'b0;
      cs_next[CS_PWR_GOOD] = 1'b0;
    end
    if (SUPPLY_LOW_LINE_IN) cs_next[CS_PWR_GOOD] = 1'b0;
    if (SYSEV_IN.parity_err) begin
      cs_next[CS_PARITY] = 1'b1;
      fault_next = 1'b1;
    end
    if (wr_pend_reg && !SYSEV_IN.write_tag_ok) begin
      cs_next[CS_WR_MISSING] = 1'b1;
      fault_next = 1'b1;
    end
    if (SYSEV_IN.read_data_seen && !SYSEV_IN.read_outstanding) begin
      cs_next[CS_UNEXP_READ] = 1'b1;
      fault_next = 1'b1;
    end
    if (mt_pend_reg) begin
      cs_next[CS_MULTI_DRV] = 1'b1;
      fault_next = 1'b1;
    end
    if (tx_pipe_reg[CONFIRM_DELAY-1] && SYS_FAULT_IN)
      cs_next[CS_SEND_ERR] = 1'b1;
    cs_next[CS_PWR_LOST] = !POWER_OK_IN;
    if (pwr_rise) cs_next[CS_PWR_GOOD] = 1'b1;
    if (!POWER_OK_IN) cs_next[CS_PWR_GOOD] = 1'b0;
    if (pwr_rise) cr_next[CR_IRQ_PERMIT] = 1'b1;
    if (SYSEV_IN.xfer_start) sr_next[SR_ACTIVE] = 1'b1;
    if (SYSEV_IN.xfer_done) sr_next[SR_ACTIVE] = 1'b0;
    if (SYSEV_IN.no_reply) begin
      sr_next[SR_NO_REPLY] = 1'b1;
      retry_next = 1'b1;
    end
    if (SYSEV_IN.corrected) sr_next[SR_CORRECTED] = 1'b1;
    // abort sequence, recorded at trailing edge
    case (ab_reg)
      // idle: only a control write starts the sequence
      AB_IDLE: ab_next = ab_next;
      AB_WAIT_EBL: if (END_OF_BLOCK_LINE_IN) ab_next = AB_WAIT_TRAIL;
      AB_WAIT_TRAIL: begin
        if (ebl_reg && !END_OF_BLOCK_LINE_IN) begin
          ab_next = AB_IDLE;
          sr_next[SR_ABORTED] = 1'b1;
          sr_next[SR_ACTIVE] = 1'b0;
        end
      end
      default: ab_next = AB_IDLE;
    endcase
    // init and bus clear cancel an abort wait outright
    if (do_init || BUS_CLEAR_LINE_IN) ab_next = AB_IDLE;
    cr_next[CR_INIT] = 1'b0;
    cs_next[28] = 1'b0;
    cs_next[25:24] = 2'b00;
    cs_next[CS_OVERHEAT] = 1'b0;
    cs_next[20:8] = 13'h0000;
    cs_next[CS_CODE_MSB:0] = ADAPTER_CODE;
    cr_next[31:4] = 28'h0000000;
    sr_next[28:20] = 9'h000;
    sr_next[18:13] = 6'h00;
    sr_next[11:0] = 12'h000;
  end

  // output group: every port is fed straight from a flop
  always_comb begin
    // deferred while busy; status flags only
    irq_src = cs_reg[CS_PWR_LOST] | cs_reg[CS_PWR_GOOD]
      | (!busy & (sr_reg[SR_MISUSE] | sr_reg[SR_ABORTED]
      | sr_reg[SR_NO_REPLY] | sr_reg[SR_CORRECTED]));
    irq_next = irq_src && cr_reg[CR_IRQ_PERMIT];
    // diag detaches drives; abort drops run
    drv_next.run = busy && !cr_reg[CR_DIAG] && ab_reg == AB_IDLE;
    drv_next.drive_request_strobe = busy && !cr_reg[CR_DIAG]
      && ab_reg == AB_IDLE;
    drv_next.detach = cr_reg[CR_DIAG];
    drv_next.transfer_exception_line = ab_reg != AB_IDLE;
    drv_next.drive_init = init_reg;
    // read word is zero outside a read, so no stale value lingers
    rdata_next = ZERO_WORD;
    if (RD_EN_IN) begin
      case (ADDR_IN)
        OFS_CONFIG_STATUS: rdata_next = cs_reg;
        OFS_CONTROL: rdata_next = cr_reg;
        OFS_STATUS: rdata_next = sr_reg;
        default: rdata_next = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      cs_reg <= ZERO_WORD;
      cr_reg <= CONTROL_RESET;
      sr_reg <= ZERO_WORD;
      fault_reg <= 1'b0;
      fault_seen_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      tx_pipe_reg <= '0;
      mt_pend_reg <= 1'b0;
      pwr_reg <= 1'b0;
      retry_reg <= 1'b0;
      init_reg <= 1'b0;
      ebl_reg <= 1'b0;
      ab_reg <= AB_IDLE;
    end else begin
      cs_reg <= cs_next;
      cr_reg <= cr_next;
      sr_reg <= sr_next;
      fault_reg <= fault_next;
      fault_seen_reg <= fault_seen_next;
      wr_pend_reg <= wr_pend_next;
      tx_pipe_reg <= tx_pipe_next;
      mt_pend_reg <= mt_pend_next;
      pwr_reg <= pwr_next;
      retry_reg <= retry_next;
      init_reg <= init_next;
      ebl_reg <= ebl_next;
      ab_reg <= ab_next;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      rdata_reg <= ZERO_WORD;
      irq_reg <= 1'b0;
      drv_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      drv_reg <= drv_next;
    end
  end

  assign RDATA_OUT = rdata_reg;
  assign SYS_FAULT_OUT = fault_reg;
  assign RETRY_OUT = retry_reg;
  assign STOP_COMMANDS_OUT = drv_reg.transfer_exception_line;
  assign IRQ_OUT = irq_reg;
  assign DRIVE_OUT = drv_reg;
endmodule : dba_regs
`default_nettype wire

// ==== test/dba_regs_props.sv ====
// checker for the adapter register block, top ports only
// bound into dba_regs after the module below
`timescale 1ns/1ps
`default_nettype none
module dba_regs_props
  import dba_pkg::*;
#(
  parameter logic [7:0] ADAPTER_CODE = ADAPTER_CODE_DEFAULT
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // register port
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [11:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic [31:0] RDATA_OUT,
  // bus and drive side
  input wire dba_pkg::dba_sysev_s SYSEV_IN,
  input wire logic SYS_FAULT_OUT,
  input wire logic STOP_COMMANDS_OUT,
  input wire dba_pkg::dba_drive_s DRIVE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  sequence s_wr_missing;
    SYSEV_IN.write_cmd_sent ##1 !SYSEV_IN.write_tag_ok;
  endsequence
  sequence s_abort_req;
    WR_EN_IN && ADDR_IN == OFS_CONTROL && WDATA_IN[1:0] == 2'h2;
  endsequence
  a_parity_fault: assert property (
    SYSEV_IN.parity_err |=> SYS_FAULT_OUT) else $error("no parity fault");
  a_write_missing: assert property (
    s_wr_missing |=> SYS_FAULT_OUT) else $error("no write fault");
  a_unexp_read: assert property (
    SYSEV_IN.read_data_seen && !SYSEV_IN.read_outstanding |=> SYS_FAULT_OUT)
    else $error("no read fault");
  a_multi_drv: assert property (
    SYSEV_IN.transmitting && SYSEV_IN.id_mismatch |-> ##2 SYS_FAULT_OUT)
    else $error("no sender fault");
  a_diag_detach: assert property (
    DRIVE_OUT.detach |-> !DRIVE_OUT.run && !DRIVE_OUT.drive_request_strobe)
    else $error("detach with run");
  a_abort_seq: assert property (
    s_abort_req |-> ##2 STOP_COMMANDS_OUT && !DRIVE_OUT.run
      && DRIVE_OUT.transfer_exception_line) else $error("abort stalled");
  a_init_drive: assert property (
    WR_EN_IN && ADDR_IN == OFS_CONTROL && WDATA_IN[0]
      |-> ##[1:2] DRIVE_OUT.drive_init) else $error("no drive init");
  // code appears one clock after release, so skip that first read
  a_code_read: assert property (
    RD_EN_IN && ADDR_IN == OFS_CONFIG_STATUS && $past(RST_N_IN) |=>
      RDATA_OUT[7:0] == ADAPTER_CODE && !RDATA_OUT[CS_OVERHEAT])
    else $error("bad type code");
endmodule : dba_regs_props
bind dba_regs dba_regs_props #(.ADAPTER_CODE(ADAPTER_CODE)) u_props (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .WR_EN_IN(WR_EN_IN),
  .RD_EN_IN(RD_EN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .RDATA_OUT(RDATA_OUT), .SYSEV_IN(SYSEV_IN), .SYS_FAULT_OUT(SYS_FAULT_OUT),
  .STOP_COMMANDS_OUT(STOP_COMMANDS_OUT), .DRIVE_OUT(DRIVE_OUT)
);
`default_nettype wire

// ==== test/dba_drive_model.sv ====
// drive-side partner: answers the exception line with end of block
// assumes the adapter holds the exception line until the pulse ends
`timescale 1ns/1ps
`default_nettype none
module dba_drive_model
  import dba_pkg::*;
#(
  parameter int LAG = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // drive bus
  input wire dba_pkg::dba_drive_s drive_in,
  output logic eob_out
);
  int cnt_reg;
  // counter saturates so one exception gives exactly one pulse
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !drive_in.transfer_exception_line)
      cnt_reg <= 0;
    else if (cnt_reg < LAG + 4)
      cnt_reg <= cnt_reg + 1;
  end
  // larger lag models a slow drive; pulse lasts three cycles
  assign eob_out = cnt_reg > LAG && cnt_reg <= LAG + 3;
endmodule : dba_drive_model
`default_nettype wire

// ==== test/dba_regs_tb_top.sv ====
// self-checking bench for the adapter register block
// assumes package, design, drive model and checker compile first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module dba_regs_tb_top;
  import dba_pkg::*;
  localparam logic [31:0] FM = 32'hEC00_0000;
  localparam logic [31:0] PM = 32'h00C0_0000;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, flt = 0, clr = 0, low = 0;
  logic pok = 0, flt_o, retry, stop, irq, eob;
  logic [11:0] adr = '0;
  logic [31:0] wd = '0, rdat;
  dba_sysev_s ev = '0;
  dba_drive_s drv;
  int n_fail = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  dba_regs dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .WR_EN_IN(wr), .RD_EN_IN(rd),
    .ADDR_IN(adr), .WDATA_IN(wd), .RDATA_OUT(rdat), .SYSEV_IN(ev),
    .SYS_FAULT_IN(flt), .BUS_CLEAR_LINE_IN(clr), .SUPPLY_LOW_LINE_IN(low),
    .POWER_OK_IN(pok), .END_OF_BLOCK_LINE_IN(eob), .SYS_FAULT_OUT(flt_o),
    .RETRY_OUT(retry), .STOP_COMMANDS_OUT(stop), .IRQ_OUT(irq),
    .DRIVE_OUT(drv)
  );
  dba_drive_model #(.LAG(4)) far (
    .clk_in(clk), .rst_n_in(rst_n), .drive_in(drv), .eob_out(eob)
  );
  task automatic close_out();
    $display("checked %0d mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1;
    adr = a;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask : wreg
  // read data stands one cycle after the strobe edge
  task automatic rreg(input logic [11:0] a, input logic [31:0] m, e);
    @(negedge clk);
    rd = 1;
    adr = a;
    @(negedge clk);
    rd = 0;
    `CHK(rdat & m, e)
  endtask : rreg
  task automatic pulse(input logic [10:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = '0;
  endtask : pulse
  // event, then error line seen after d cycles, then released
  task automatic flag(input logic [10:0] v, input int d, logic [31:0] e);
    pulse(v);
    idle(d);
    flt = 1;
    rreg(OFS_CONFIG_STATUS, FM, e);
    flt = 0;
    idle(2);
    rreg(OFS_CONFIG_STATUS, FM, '0);
  endtask : flag
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    rreg(OFS_CONTROL, '1, CONTROL_RESET);
    // power is still down here, so bit 23 reads one
    rreg(OFS_CONFIG_STATUS, '1, {24'h00_8000, ADAPTER_CODE_DEFAULT});
    rreg(12'h00C, '1, ZERO_WORD);
    $display("reset values done");
    flag(11'h400, 4, 32'h8000_0000);
    flag(11'h200, 4, 32'h4000_0000);
    flag(11'h080, 4, 32'h2000_0000);
    flag(11'h0C0, 4, ZERO_WORD);
    flag(11'h030, 4, 32'h0800_0000);
    flag(11'h020, 1, 32'h0400_0000);
    $display("fault flags done");
    pok = 1;
    idle(3);
    `CHK(irq, 1'b1)
    rreg(OFS_CONFIG_STATUS, PM, 32'h0040_0000);
    wreg(OFS_CONFIG_STATUS, 32'h0040_0000);
    rreg(OFS_CONFIG_STATUS, PM, ZERO_WORD);
    `CHK(irq, 1'b0)
    pok = 0;
    idle(3);
    `CHK(irq, 1'b1)
    rreg(OFS_CONFIG_STATUS, PM, 32'h0080_0000);
    pok = 1;
    idle(3);
    rreg(OFS_CONFIG_STATUS, PM, 32'h0040_0000);
    low = 1;
    rreg(OFS_CONFIG_STATUS, PM, ZERO_WORD);
    low = 0;
    $display("power flags done");
    wreg(OFS_CONTROL, 32'h0000_000C);
    idle(2);
    `CHK({drv.detach, drv.run, drv.drive_request_strobe}, 3'b100)
    wreg(OFS_CONTROL, CONTROL_RESET);
    pulse(11'h002);
    rreg(OFS_STATUS, 32'h8008_0000, 32'h8000_0000);
    wreg(OFS_CONTROL, 32'h0000_000C);
    rreg(OFS_CONTROL, '1, CONTROL_RESET);
    rreg(OFS_STATUS, 32'h8008_0000, 32'h8008_0000);
    `CHK(irq, 1'b0)
    wreg(OFS_CONTROL, 32'h0000_0006);
    idle(2);
    `CHK({stop, drv.run, drv.transfer_exception_line}, 3'b101)
    for (int i = 0; i < 40 && stop; i++)
      @(negedge clk);
    rreg(OFS_STATUS, 32'h8008_1000, 32'h0008_1000);
    `CHK(irq, 1'b1)
    rreg(OFS_CONTROL, 32'h2, 32'h2);
    clr = 1;
    idle(1);
    clr = 0;
    rreg(OFS_CONTROL, 32'h2, ZERO_WORD);
    $display("transfer and abort done");
    wreg(OFS_CONTROL, CONTROL_RESET);
    pulse(11'h00C);
    `CHK(retry, 1'b1)
    rreg(OFS_STATUS, 32'h6000_0000, 32'h6000_0000);
    wreg(OFS_STATUS, 32'h4000_0000);
    rreg(OFS_STATUS, 32'h6000_0000, 32'h2000_0000);
    pulse(11'h400);
    `CHK(flt_o, 1'b1)
    wreg(OFS_CONTROL, 32'h0000_0001);
    idle(1);
    `CHK(drv.drive_init, 1'b1)
    rreg(OFS_STATUS, '1, ZERO_WORD);
    rreg(OFS_CONTROL, '1, ZERO_WORD);
    rreg(OFS_CONFIG_STATUS, FM, ZERO_WORD);
    wreg(OFS_CONTROL, 32'hFFFF_FFF0);
    rreg(OFS_CONTROL, '1, ZERO_WORD);
    $display("status and init done");
    close_out();
  end
endmodule : dba_regs_tb_top
`default_nettype wire
